/* File: rtl/lsrb_pkg.sv */
package lsrb_pkg;
  // ---------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------
  localparam int NUM_FP = 32;
  localparam int NUM_BP = 4;
  localparam int RAM_BYTES = 16;
  localparam int FP_PER_BYTE = 2;

  // ---------------------------------------------------------------
  // APB byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CMD = 8'h04;
  localparam logic [7:0] ADDR_BLINK = 8'h08;
  localparam logic [7:0] ADDR_FPEN = 8'h0C;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_RAM_BASE = 8'h40;
  localparam logic [7:0] ADDR_RAM_LAST = 8'h7C;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_DUTY_LSB = 1;
  localparam int CTRL_LOW_POWER_WAVE_SEL_BIT = 3;
  localparam int CTRL_PRESC_LSB = 4;
  localparam int CTRL_BLANK_BIT = 7;
  localparam int CMD_BANK_BIT = 0;
  localparam int CMD_CLEAR_BIT = 1;
  localparam int BLK_ON_BIT = 0;
  localparam int BLK_ALL_BIT = 1;
  localparam int BLK_RATE_LSB = 2;

  // ---------------------------------------------------------------
  // Reset values and encodings
  // ---------------------------------------------------------------
  localparam logic [1:0] DUTY_HALF = 2'h1;
  localparam logic [1:0] DUTY_THIRD = 2'h2;
  localparam logic [1:0] DUTY_QUARTER = 2'h3;
  localparam logic [1:0] DUTY_RESET = 2'h3;
  localparam logic [31:0] FPEN_RESET = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Divider constants
  // ---------------------------------------------------------------
  localparam logic [11:0] BASE_DIV_UNIT = 12'h010;  // 16 input edges
  localparam logic [12:0] BLINK_DIV_UNIT = 13'h0020; // 2 to the 5th

  // Backplane phase, Gray coded along the scan
  typedef enum logic [1:0] {
    LSRB_BP0 = 2'b00,
    LSRB_BP1 = 2'b01,
    LSRB_BP2 = 2'b11,
    LSRB_BP3 = 2'b10
  } lsrb_phase_t;
endpackage

/* File: rtl/lsrb_top.sv */
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
module lsrb_top
  import lsrb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic display_clk_in,
  output logic [NUM_FP-1:0] frontplane_output,
  output logic [NUM_BP-1:0] backplane_output,
  output logic drive_polarity
);

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic display_enable_r;
  logic [1:0] duty_select_r;
  logic low_power_wave_sel_r;
  logic [2:0] base_clock_prescale_r;
  logic blank_r;
  logic ram_bank_select_r;
  logic ram_clear_cmd_r;
  logic blink_ctrl_r;
  logic all_segment_blink_sel_r;
  logic [2:0] blink_rate_select_r;
  logic [NUM_FP-1:0] frontplane_enable_r;
  logic [7:0] data_bank_r [RAM_BYTES];
  logic [7:0] blink_bank_r [RAM_BYTES];
  logic [31:0] prdata_r;
  logic pslverr_r;

  // Timing state
  logic clk_in_d_r;
  logic [10:0] base_cnt_r;
  lsrb_phase_t phase_r;
  lsrb_phase_t phase_nxt;
  logic [1:0] phase_r_idx;
  logic [11:0] blink_cnt_r;
  logic blink_active_r;
  logic blink_off_r;
  logic [NUM_FP-1:0] fp_seg_r;
  logic [NUM_BP-1:0] bp_r;
  logic pol_r;

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  logic wr_en;
  logic setup;
  logic ram_hit;
  logic [3:0] ram_idx;
  logic mapped;

  assign wr_en = psel & penable & pwrite;
  assign setup = psel & ~penable;
  assign ram_hit = (paddr >= ADDR_RAM_BASE) && (paddr <= ADDR_RAM_LAST) &&
                   (paddr[1:0] == 2'h0);
  assign ram_idx = paddr[5:2];
  assign mapped = ram_hit || paddr == ADDR_CTRL || paddr == ADDR_CMD ||
                  paddr == ADDR_BLINK || paddr == ADDR_FPEN ||
                  paddr == ADDR_STATUS;
  // Zero wait states; read data is captured in the setup cycle
  assign pready = 1'b1;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  // Control register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      display_enable_r <= 1'b0;
      duty_select_r <= DUTY_RESET;
      low_power_wave_sel_r <= 1'b0;
      base_clock_prescale_r <= 3'h0;
      blank_r <= 1'b0;
      blink_ctrl_r <= 1'b0;
      all_segment_blink_sel_r <= 1'b0;
      blink_rate_select_r <= 3'h0;
      frontplane_enable_r <= FPEN_RESET;
      ram_bank_select_r <= 1'b0;
    end else if (wr_en) begin
      case (paddr)
        ADDR_CTRL: begin
          display_enable_r <= pwdata[CTRL_EN_BIT];
          duty_select_r <= pwdata[CTRL_DUTY_LSB +: 2];
          low_power_wave_sel_r <= pwdata[CTRL_LOW_POWER_WAVE_SEL_BIT];
          base_clock_prescale_r <= pwdata[CTRL_PRESC_LSB +: 3];
          blank_r <= pwdata[CTRL_BLANK_BIT];
        end
        ADDR_CMD: ram_bank_select_r <= pwdata[CMD_BANK_BIT];
        ADDR_BLINK: begin
          blink_ctrl_r <= pwdata[BLK_ON_BIT];
          all_segment_blink_sel_r <= pwdata[BLK_ALL_BIT];
          blink_rate_select_r <= pwdata[BLK_RATE_LSB +: 3];
        end
        ADDR_FPEN: frontplane_enable_r <= pwdata;
        default: ;
      endcase
    end
  end

  // self-clearing strobe
  // Clear finishes in one cycle, so the bit reads 1 for one cycle only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ram_clear_cmd_r <= 1'b0;
    end else begin
      ram_clear_cmd_r <= wr_en && paddr == ADDR_CMD && pwdata[CMD_CLEAR_BIT];
    end
  end

  // ---------------------------------------------------------------
  // Segment RAM, two banks
  // ---------------------------------------------------------------
  // No reset: contents are undefined until software writes them.
  // Only the RAM window and the clear strobe touch the banks, so
  // control, enable and blank writes never disturb them.
  genvar gi;
  generate
    for (gi = 0; gi < RAM_BYTES; gi++) begin : g_ram
      always_ff @(posedge pclk) begin
        if (ram_clear_cmd_r && !ram_bank_select_r) begin
          data_bank_r[gi] <= 8'h00;
        end else if (wr_en && ram_hit && ram_idx == 4'(gi) &&
                     !ram_bank_select_r) begin
          data_bank_r[gi] <= pwdata[7:0];
        end
      end
      always_ff @(posedge pclk) begin
        if (ram_clear_cmd_r && ram_bank_select_r) begin
          blink_bank_r[gi] <= 8'h00;
        end else if (wr_en && ram_hit && ram_idx == 4'(gi) &&
                     ram_bank_select_r) begin
          blink_bank_r[gi] <= pwdata[7:0];
        end
      end
    end
  endgenerate

  // Read mux, captured in setup so prdata is a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else if (setup) begin
      pslverr_r <= !mapped;
      prdata_r <= 32'h0000_0000;
      if (ram_hit) begin
        prdata_r[7:0] <= ram_bank_select_r ? blink_bank_r[ram_idx] :
                                             data_bank_r[ram_idx];
      end else begin
        case (paddr)
          ADDR_CTRL: prdata_r[7:0] <= {blank_r, base_clock_prescale_r,
                                       low_power_wave_sel_r, duty_select_r,
                                       display_enable_r};
          ADDR_CMD: prdata_r[1:0] <= {ram_clear_cmd_r, ram_bank_select_r};
          ADDR_BLINK: prdata_r[4:0] <= {blink_rate_select_r,
                                        all_segment_blink_sel_r,
                                        blink_ctrl_r};
          ADDR_FPEN: prdata_r <= frontplane_enable_r;
          ADDR_STATUS: prdata_r[3:0] <= {blink_off_r, blink_active_r,
                                         phase_r};
          default: ;
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // Waveform timing generator
  // ---------------------------------------------------------------
  logic clk_rise;
  logic [11:0] base_div;
  logic base_tick;
  logic frame_start;
  lsrb_phase_t last_phase;

  assign clk_rise = display_clk_in & ~clk_in_d_r;
  // base divider is 16 times 2 to prescale
  assign base_div = BASE_DIV_UNIT << base_clock_prescale_r;
  // Compare with >= so a smaller prescale never strands the counter high
  assign base_tick = clk_rise && base_cnt_r >= 11'(base_div - 12'h001);

  // duty decode; 00 is treated as quarter duty
  always_comb begin
    case (duty_select_r)
      DUTY_HALF: last_phase = LSRB_BP1;
      DUTY_THIRD: last_phase = LSRB_BP2;
      default: last_phase = LSRB_BP3;
    endcase
  end

  // frame closes after the last active backplane
  assign frame_start = base_tick && phase_r == last_phase;

  always_comb begin
    case (phase_r)
      LSRB_BP0: phase_nxt = LSRB_BP1;
      LSRB_BP1: phase_nxt = LSRB_BP2;
      LSRB_BP2: phase_nxt = LSRB_BP3;
      default: phase_nxt = LSRB_BP0;
    endcase
    if (phase_r == last_phase) begin
      phase_nxt = LSRB_BP0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_in_d_r <= 1'b0;
    end else begin
      clk_in_d_r <= display_clk_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_cnt_r <= 11'h000;
      phase_r <= LSRB_BP0;
    end else if (!display_enable_r) begin
      base_cnt_r <= 11'h000;
      phase_r <= LSRB_BP0;
    end else if (clk_rise) begin
      base_cnt_r <= base_tick ? 11'h000 : base_cnt_r + 11'h001;
      if (base_tick) begin
        phase_r <= phase_nxt;
      end
    end
  end

  // normal inverts each phase, low power each frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pol_r <= 1'b0;
    end else if (display_enable_r &&
                 (low_power_wave_sel_r ? frame_start : base_tick)) begin
      pol_r <= ~pol_r;
    end
  end

  // ---------------------------------------------------------------
  // Blink generator
  // ---------------------------------------------------------------
  logic [12:0] blink_div;
  logic [11:0] blink_top;
  logic blink_half;

  // divider of 2 to the (5 + rate), 32 up to 4096
  assign blink_div = BLINK_DIV_UNIT << blink_rate_select_r;
  assign blink_top = 12'(blink_div - 13'h0001);
  // second half of the period is the off half
  assign blink_half = {1'b0, blink_cnt_r} >= (blink_div >> 1);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt_r <= 12'h000;
    end else if (!blink_active_r) begin
      blink_cnt_r <= 12'h000;
    end else if (base_tick) begin
      blink_cnt_r <= (blink_cnt_r >= blink_top) ? 12'h000 :
                     blink_cnt_r + 12'h001;
    end
  end

  // blink bit sampled only at a frame start
  // on/off halves switch on frame edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_active_r <= 1'b0;
      blink_off_r <= 1'b0;
    end else if (!display_enable_r) begin
      blink_active_r <= 1'b0;
      blink_off_r <= 1'b0;
    end else if (frame_start) begin
      blink_active_r <= blink_ctrl_r;
      blink_off_r <= blink_ctrl_r && blink_active_r && blink_half;
    end
  end

  // ---------------------------------------------------------------
  // Segment and backplane drive
  // ---------------------------------------------------------------
  // byte n/2 holds frontplanes 2k and 2k+1, four bits each
  generate
    for (gi = 0; gi < NUM_FP; gi++) begin : g_fp
      logic seg_on;
      logic seg_blink;
      // one bit per crossing of frontplane and backplane
      assign seg_on = data_bank_r[gi / FP_PER_BYTE]
                      [(gi % FP_PER_BYTE) * NUM_BP + int'(phase_r_idx)];
      assign seg_blink = all_segment_blink_sel_r ||
                         blink_bank_r[gi / FP_PER_BYTE]
                         [(gi % FP_PER_BYTE) * NUM_BP + int'(phase_r_idx)];
      // enable gates the drive, blank forces off
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          fp_seg_r[gi] <= 1'b0;
        end else begin
          fp_seg_r[gi] <= display_enable_r && frontplane_enable_r[gi] &&
                          !blank_r && seg_on &&
                          !(blink_off_r && seg_blink);
        end
      end
    end
  endgenerate

  // Gray phase to backplane index
  always_comb begin
    case (phase_r)
      LSRB_BP0: phase_r_idx = 2'h0;
      LSRB_BP1: phase_r_idx = 2'h1;
      LSRB_BP2: phase_r_idx = 2'h2;
      default: phase_r_idx = 2'h3;
    endcase
  end

  generate
    for (gi = 0; gi < NUM_BP; gi++) begin : g_bp
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          bp_r[gi] <= 1'b0;
        end else begin
          bp_r[gi] <= display_enable_r && phase_r_idx == 2'(gi);
        end
      end
    end
  endgenerate

  assign frontplane_output = fp_seg_r;
  assign backplane_output = bp_r;
  assign drive_polarity = pol_r;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  logic [8*RAM_BYTES-1:0] data_flat;
  logic [8*RAM_BYTES-1:0] blink_flat;
  generate
    for (gi = 0; gi < RAM_BYTES; gi++) begin : g_flat
      assign data_flat[gi*8 +: 8] = data_bank_r[gi];
      assign blink_flat[gi*8 +: 8] = blink_bank_r[gi];
    end
  endgenerate

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  duty_half_bp_a: assert property (
    duty_select_r == DUTY_HALF |=> ##1 backplane_output[3:2] == 2'h0)
    else $error("half duty drove an unused backplane");
  lp_wave_pol_a: assert property (
    low_power_wave_sel_r && base_tick && !frame_start |=> $stable(pol_r))
    else $error("low-power wave inverted mid-frame");
  clear_bank_a: assert property (
    ram_clear_cmd_r && !ram_bank_select_r |=>
      data_flat == '0 && $stable(blink_flat))
    else $error("clear touched the wrong bank");
  clear_self_a: assert property (
    ram_clear_cmd_r |=> !ram_clear_cmd_r)
    else $error("clear command did not self-clear");
  blank_off_a: assert property (
    blank_r [*2] |-> frontplane_output == '0)
    else $error("segment driven while blanked");
  blank_runs_a: assert property (
    blank_r && display_enable_r && base_tick |=> phase_r != $past(phase_r))
    else $error("timing stalled while blanked");
  blink_frame_a: assert property (
    !frame_start && display_enable_r |=> $stable(blink_active_r))
    else $error("blink state changed mid-frame");
  ctrl_ram_keep_a: assert property (
    wr_en && paddr == ADDR_CTRL |=> $stable(data_flat))
    else $error("control write altered segment RAM");
  disabled_off_a: assert property (
    !display_enable_r [*2] |-> frontplane_output == '0)
    else $error("segment driven with display off");

  clear_seen_c: cover property (ram_clear_cmd_r && ram_bank_select_r);
  blink_off_c: cover property (blink_off_r && frame_start);
  lp_frame_c: cover property (low_power_wave_sel_r && frame_start);
endmodule

/* File: tb/lsrb_panel_model.sv */
`timescale 1ns/10ps
// --------------------------------------------------------
// Glass panel: one lit cell per frontplane/backplane pair
// --------------------------------------------------------
module lsrb_panel_model
  import lsrb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clear_seen,
  input wire logic [NUM_FP-1:0] frontplane_output,
  input wire logic [NUM_BP-1:0] backplane_output,
  output logic [4*NUM_FP-1:0] img,
  output logic [NUM_BP-1:0] bp_seen
);
  // Phases without a single active backplane light nothing
  // crossing to cell
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      img <= '0;
      bp_seen <= '0;
    end else if (clear_seen) begin
      img <= '0;
      bp_seen <= '0;
    end else if ($onehot(backplane_output)) begin
      bp_seen <= bp_seen | backplane_output;
      for (int f = 0; f < NUM_FP; f++) begin
        for (int b = 0; b < NUM_BP; b++) begin
          if (backplane_output[b]) begin
            img[f*NUM_BP+b] <= frontplane_output[f];
          end
        end
      end
    end
  end
endmodule

/* File: tb/lsrb_top_tb_top.sv */
`timescale 1ns/10ps
module lsrb_top_tb_top;
  import lsrb_pkg::*;
  // --------------------------------------------------------
  // Stimulus, design and panel
  // --------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic display_clk_in = 1'b0;
  logic clear_seen = 1'b0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [NUM_FP-1:0] frontplane_output;
  logic [NUM_BP-1:0] backplane_output;
  logic drive_polarity;
  logic [4*NUM_FP-1:0] img;
  logic [NUM_BP-1:0] bp_seen;
  int miscompares = 0;
  int total_checks = 0;

  lsrb_top lsrb_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .display_clk_in(display_clk_in), .frontplane_output(frontplane_output),
    .backplane_output(backplane_output), .drive_polarity(drive_polarity));
  lsrb_panel_model lsrb_panel_model_i (.pclk(pclk), .presetn(presetn),
    .clear_seen(clear_seen), .frontplane_output(frontplane_output),
    .backplane_output(backplane_output), .img(img), .bp_seen(bp_seen));

  // Display clock rises every second pclk, so a base tick is 32 pclk at prescale 0
  always #10 pclk = ~pclk;
  always @(posedge pclk) display_clk_in <= ~display_clk_in;

  task automatic chk(input string nm, input logic [127:0] x, y);
    total_checks++;
    if (y !== x) begin
      miscompares++;
      $display("unexpected %s expected %0h seen %0h", nm, x, y);
    end
  endtask

  // APB master: request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask

  function automatic logic [7:0] pat(logic [7:0] s, st, int k);
    return s ^ (st * 8'(k));
  endfunction

  function automatic logic [127:0] exp_img(logic [7:0] s, st);
    logic [127:0] m;
    for (int k = 0; k < RAM_BYTES; k++) m[8*k +: 8] = pat(s, st, k);
    return m;
  endfunction

  // Bank select first, then every byte of the window
  task automatic fill(input logic bank, input logic [7:0] s, st);
    wr(ADDR_CMD, 32'(bank));
    for (int k = 0; k < RAM_BYTES; k++) begin
      wr(ADDR_RAM_BASE + 8'(4*k), 32'(pat(s, st, k)));
    end
  endtask

  task automatic ram(output logic [127:0] m);
    logic [31:0] q;
    for (int k = 0; k < RAM_BYTES; k++) begin
      rd(ADDR_RAM_BASE + 8'(4*k), q);
      m[8*k +: 8] = q[7:0];
    end
  endtask

  task automatic wait_bp(input logic [3:0] m);
    int n;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (backplane_output !== m && n < 2000);
  endtask

  task automatic wait_fp0(input logic v, output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (frontplane_output[0] !== v && n < 5000);
  endtask

  // Counts pclk and polarity flips across c phase changes
  task automatic scan(input int c, output int cyc, output int tg);
    logic [3:0] b;
    logic pol;
    int ch;
    ch = 0;
    cyc = 0;
    tg = 0;
    b = backplane_output;
    pol = drive_polarity;
    while (ch < c && cyc < 20000) begin
      @(posedge pclk);
      cyc++;
      if (backplane_output !== b) ch++;
      if (drive_polarity !== pol) tg++;
      b = backplane_output;
      pol = drive_polarity;
    end
  endtask

  task automatic t_ram;
    logic [127:0] m;
    logic [31:0] q;
    logic e;
    fill(1'b1, 8'hC3, 8'h11);
    fill(1'b0, 8'h00, 8'h11);
    wr(ADDR_CTRL, 32'h0);
    ram(m);
    chk("bank0 data", exp_img(8'h00, 8'h11), m);
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_CTRL, 32'h0);
    ram(m);
    chk("bank0 after enable", exp_img(8'h00, 8'h11), m);
    wr(ADDR_CMD, 32'h1);
    ram(m);
    chk("bank1 data", exp_img(8'hC3, 8'h11), m);
    apb(1'b0, 8'h20, 32'h0, q, e);
    chk("unmapped error", 1, e);
    chk("unmapped data", 0, q);
  endtask

  task automatic t_clear;
    logic [127:0] m;
    logic [31:0] q;
    int n;
    wr(ADDR_CMD, 32'h3);
    n = 0;
    do begin
      rd(ADDR_CMD, q);
      n++;
    end while (q[1] !== 1'b0 && n < 10);
    chk("clear bit", 0, q[1]);
    ram(m);
    chk("cleared bank1", 0, m);
    wr(ADDR_CMD, 32'h0);
    ram(m);
    chk("kept bank0", exp_img(8'h00, 8'h11), m);
  endtask

  task automatic t_display;
    logic [7:0] m8;
    fill(1'b0, 8'h96, 8'h35);
    wr(ADDR_FPEN, 32'hFFFF_FFFF);
    for (int d = 1; d <= 3; d++) begin
      m8 = (d == 1) ? 8'h33 : (d == 2) ? 8'h77 : 8'hFF;
      wr(ADDR_CTRL, 32'h1 | 32'(d) << 1);
      repeat (60) @(posedge pclk);
      clear_seen <= 1'b1;
      @(posedge pclk);
      clear_seen <= 1'b0;
      repeat (300) @(posedge pclk);
      chk("panel image", exp_img(8'h96, 8'h35) & {16{m8}}, img);
      chk("backplanes", m8[3:0], bp_seen);
    end
  endtask

  task automatic t_timing(input logic [2:0] p, input logic lp);
    int cyc;
    int tg;
    wr(ADDR_CTRL, 32'h7 | 32'(lp) << 3 | 32'(p) << 4);
    scan(2, cyc, tg);
    scan(8, cyc, tg);
    chk("phase span", 128'(8 * (32 << p)), 128'(cyc));
    chk("inversions", lp ? 2 : 8, 128'(tg));
  endtask

  task automatic t_blank;
    logic [127:0] m;
    wr(ADDR_CTRL, 32'h87);
    clear_seen <= 1'b1;
    @(posedge pclk);
    clear_seen <= 1'b0;
    repeat (300) @(posedge pclk);
    chk("blank image", 0, img);
    chk("blank timing", 4'hF, bp_seen);
    ram(m);
    chk("blank ram", exp_img(8'h96, 8'h35), m);
  endtask

  task automatic t_blink;
    logic [31:0] q;
    int n;
    int lo;
    int hi;
    fill(1'b1, 8'h00, 8'h00);
    wr(ADDR_RAM_BASE, 32'h0F);
    fill(1'b0, 8'hFF, 8'h00);
    wr(ADDR_CTRL, 32'h7);
    wait_bp(4'b0010);
    wr(ADDR_BLINK, 32'h1);
    rd(ADDR_STATUS, q);
    chk("blink mid frame", 0, q[2]);
    wait_bp(4'b0001);
    rd(ADDR_STATUS, q);
    chk("blink at frame", 1, q[2]);
    n = 0;
    do begin
      rd(ADDR_STATUS, q);
      n++;
    end while (q[3] !== 1'b1 && n < 400);
    wait_bp(4'b0001);
    repeat (2) @(posedge pclk);
    chk("one segment off", 3'b110, frontplane_output[2:0]);
    wr(ADDR_BLINK, 32'h7);
    wait_fp0(1'b0, n);
    wait_fp0(1'b1, n);
    wait_fp0(1'b0, n);
    repeat (200) @(posedge pclk);
    chk("all off", 0, frontplane_output);
    wait_fp0(1'b1, lo);
    wait_fp0(1'b0, hi);
    chk("off half", 1024, 128'(lo + 200));
    chk("on half", 1024, 128'(hi));
    wr(ADDR_BLINK, 32'h0);
  endtask

  task automatic end_of_test;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence after a three-cycle reset
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_ram();
    t_clear();
    t_display();
    t_timing(3'd0, 1'b0);
    t_timing(3'd1, 1'b1);
    t_blank();
    t_blink();
    end_of_test();
  end

  // Watchdog well beyond the expected run of about 6000 cycles
  initial begin
    repeat (80000) @(posedge pclk);
    miscompares++;
    end_of_test();
  end
endmodule
